/* File: core/crpc_core_reset_power.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Warm and cold resets are active low, any timing, both raise reset.
// - Any reset gives an internal pulse of at least six cycles, released on the clock.
// - Warm low with cold high resets and sets the soft-reset flag.
// - Cold low always resets; both high means normal operation.
// - Cold never masked; warm maskable only in debug mode on request.
// - Exception-level output follows status bit 1.
// - Error-level output follows status bit 2.
// - Debug-mode output follows debug register bit 30.
// - Wait stops the core clock; timer, interrupts and resets stay live.
// - Any interrupt, NMI or reset ends wait mode.
// - Sleep output asserts when a wait instruction executes with no reset, interrupt, NMI or timer event pending.
module crpc_core_reset_power #(
	parameter int INT_W   = 8,
	parameter int TIMER_W = 32
) (
	// Clock and reset
	input  wire logic                          mclk,
	input  wire logic                          nrst,
	// Core reset and wake sources
	input  wire logic                          warmResetNIn,
	input  wire logic                          coldResetNIn,
	input  wire logic [INT_W-1:0]              intIn,
	input  wire logic                          nmiIn,
	// Power agent outputs
	output logic                               exceptionLevelOut,
	output logic                               errorLevelOut,
	output logic                               debugModeOut,
	output logic                               sleepOut,
	output logic                               coreClockEnOut,
	output logic                               coreResetNOut,
	// AXI4-Lite write address
	input  wire logic                          awvalid,
	output logic                               awready,
	input  wire logic [crpc_pkg::ADDR_W-1:0]   awaddr,
	input  wire logic [2:0]                    awprot,
	// AXI4-Lite write data
	input  wire logic                          wvalid,
	output logic                               wready,
	input  wire logic [crpc_pkg::DATA_W-1:0]   wdata,
	input  wire logic [crpc_pkg::STRB_W-1:0]   wstrb,
	// AXI4-Lite write response
	output logic                               bvalid,
	input  wire logic                          bready,
	output logic [1:0]                         bresp,
	// AXI4-Lite read address
	input  wire logic                          arvalid,
	output logic                               arready,
	input  wire logic [crpc_pkg::ADDR_W-1:0]   araddr,
	input  wire logic [2:0]                    arprot,
	// AXI4-Lite read data
	output logic                               rvalid,
	input  wire logic                          rready,
	output logic [crpc_pkg::DATA_W-1:0]        rdata,
	output logic [1:0]                         rresp
);
	import crpc_pkg::*;

	// =================================================================
	// Declarations
	logic [1:0]         rstMeta_ff;
	logic [1:0]         rstSync_ff;
	logic [2:0]         pulseCnt_ff;
	logic [2:0]         nxt_pulseCnt;
	logic               coreResetN_ff;
	logic               exceptionLevelBit_ff;
	logic               errorLevelBit_ff;
	logic               softResetFlag_ff;
	logic               debugModeBit_ff;
	logic               warmMaskReq_ff;
	crpc_state_e        state_ff;
	crpc_state_e        nxt_state;
	logic [3:0]         divCnt_ff;
	logic [TIMER_W-1:0] timerCount_ff;
	logic [TIMER_W-1:0] timerCmp_ff;
	logic               timerPend_ff;
	logic               awHeld_ff;
	logic [ADDR_W-1:0]  awAddr_ff;
	logic               wHeld_ff;
	logic [DATA_W-1:0]  wData_ff;
	logic [STRB_W-1:0]  wStrb_ff;
	logic               bvalid_ff;
	logic [1:0]         bresp_ff;
	logic               rvalid_ff;
	logic [DATA_W-1:0]  rdata_ff;
	logic [1:0]         rresp_ff;

	// =================================================================
	// Reset input synchronisers, bit 0 warm and bit 1 cold
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			rstMeta_ff <= 2'h3;
			rstSync_ff <= 2'h3;
		end else begin
			rstMeta_ff <= {coldResetNIn, warmResetNIn};
			rstSync_ff <= rstMeta_ff;
		end
	end

	// =================================================================
	// Reset request decode
	wire warmLow    = !rstSync_ff[0];
	wire coldLow    = !rstSync_ff[1];
	wire warmMasked = debugModeBit_ff && warmMaskReq_ff;
	wire warmReq    = warmLow && !warmMasked;
	wire resetReq   = coldLow || warmReq;
	wire softReq    = warmReq && !coldLow;
	wire resetAct   = pulseCnt_ff != 3'h0;

	// =================================================================
	// Internal reset pulse
	// six-cycle stretch
	assign nxt_pulseCnt = resetReq ? RST_PULSE :
		(resetAct ? pulseCnt_ff - 3'h1 : 3'h0);

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			pulseCnt_ff   <= RST_PULSE;
			coreResetN_ff <= 1'h0;
		end else begin
			pulseCnt_ff   <= nxt_pulseCnt;
			coreResetN_ff <= nxt_pulseCnt == 3'h0;
		end
	end

	// =================================================================
	// Bus write channel
	wire doWrite = awHeld_ff && wHeld_ff && !bvalid_ff;
	assign awready = !awHeld_ff && !bvalid_ff;
	assign wready  = !wHeld_ff && !bvalid_ff;

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			awHeld_ff <= 1'h0;
			awAddr_ff <= '0;
		end else if (awvalid && awready) begin
			awHeld_ff <= 1'h1;
			awAddr_ff <= awaddr;
		end else if (doWrite) begin
			awHeld_ff <= 1'h0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			wHeld_ff <= 1'h0;
			wData_ff <= '0;
			wStrb_ff <= '0;
		end else if (wvalid && wready) begin
			wHeld_ff <= 1'h1;
			wData_ff <= wdata;
			wStrb_ff <= wstrb;
		end else if (doWrite) begin
			wHeld_ff <= 1'h0;
		end
	end

	// Write address decode
	wire [ADDR_W-3:0] wIdx = awAddr_ff[ADDR_W-1:2];
	wire hitWStatus = wIdx == STATUS_OFF[ADDR_W-1:2];
	wire hitWDebug  = wIdx == DEBUG_OFF[ADDR_W-1:2];
	wire hitWPower  = wIdx == POWER_OFF[ADDR_W-1:2];
	wire hitWCount  = wIdx == TCOUNT_OFF[ADDR_W-1:2];
	wire hitWCmp    = wIdx == TCMP_OFF[ADDR_W-1:2];
	wire hitWAny    = hitWStatus || hitWDebug || hitWPower ||
		hitWCount || hitWCmp;
	wire wrStatus   = doWrite && hitWStatus && wStrb_ff[0];
	wire wrDbgLo    = doWrite && hitWDebug && wStrb_ff[0];
	wire wrDbgHi    = doWrite && hitWDebug && wStrb_ff[3];
	wire wrPower    = doWrite && hitWPower && wStrb_ff[0];

	// Byte-lane merge for the timer words
	wire [DATA_W-1:0] laneMask = {{8{wStrb_ff[3]}}, {8{wStrb_ff[2]}},
		{8{wStrb_ff[1]}}, {8{wStrb_ff[0]}}};

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			bvalid_ff <= 1'h0;
			bresp_ff  <= RESP_OKAY;
		end else if (doWrite) begin
			bvalid_ff <= 1'h1;
			bresp_ff  <= hitWAny ? RESP_OKAY : RESP_SLVERR;
		end else if (bready) begin
			bvalid_ff <= 1'h0;
		end
	end
	assign bvalid = bvalid_ff;
	assign bresp  = bresp_ff;

	// =================================================================
	// Status register bits
	// exception level store
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			exceptionLevelBit_ff <= EXL_RST;
		end else if (wrStatus) begin
			exceptionLevelBit_ff <= wData_ff[EXL_BIT];
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			errorLevelBit_ff <= ERL_RST;
		end else if (resetAct) begin
			errorLevelBit_ff <= 1'h1;
		end else if (wrStatus) begin
			errorLevelBit_ff <= wData_ff[ERL_BIT];
		end
	end

	// soft flag, set wins over clear
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			softResetFlag_ff <= 1'h0;
		end else if (softReq) begin
			softResetFlag_ff <= 1'h1;
		end else if (coldLow) begin
			softResetFlag_ff <= 1'h0;
		end else if (wrStatus && wData_ff[SOFT_BIT]) begin
			softResetFlag_ff <= 1'h0;
		end
	end

	// =================================================================
	// Debug register bits
	// debug mode store
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			debugModeBit_ff <= 1'h0;
		end else if (coldLow) begin
			debugModeBit_ff <= 1'h0;
		end else if (wrDbgHi) begin
			debugModeBit_ff <= wData_ff[DM_BIT];
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			warmMaskReq_ff <= 1'h0;
		end else if (coldLow) begin
			warmMaskReq_ff <= 1'h0;
		end else if (wrDbgLo) begin
			warmMaskReq_ff <= wData_ff[WMASK_BIT];
		end
	end

	assign exceptionLevelOut = exceptionLevelBit_ff;
	assign errorLevelOut     = errorLevelBit_ff;
	assign debugModeOut      = debugModeBit_ff;

	// =================================================================
	// Free-running timer, live during sleep
	// timer keeps counting
	wire tick = divCnt_ff == TIMER_DIV - 4'h1;
	wire hitTimer = tick && timerCount_ff == timerCmp_ff;

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			divCnt_ff <= 4'h0;
		end else begin
			divCnt_ff <= tick ? 4'h0 : divCnt_ff + 4'h1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			timerCount_ff <= '0;
		end else if (doWrite && hitWCount) begin
			timerCount_ff <= (timerCount_ff & ~laneMask) |
				(wData_ff & laneMask);
		end else if (tick) begin
			timerCount_ff <= timerCount_ff + 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			timerCmp_ff <= TCMP_RST;
		end else if (doWrite && hitWCmp) begin
			timerCmp_ff <= (timerCmp_ff & ~laneMask) |
				(wData_ff & laneMask);
		end
	end

	// Timer pending, set wins over write-one clear
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			timerPend_ff <= 1'h0;
		end else if (hitTimer) begin
			timerPend_ff <= 1'h1;
		end else if (wrPower && wData_ff[TPEND_BIT]) begin
			timerPend_ff <= 1'h0;
		end
	end

	// =================================================================
	// Power state machine
	// interrupt inputs stay live
	wire intEvt  = (|intIn) || nmiIn || timerPend_ff;
	wire waitCmd = wrPower && wData_ff[WAIT_BIT];

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			CRPC_RUN: begin
				if (resetReq || resetAct) begin
					nxt_state = CRPC_RESET;
				end else if (waitCmd && !intEvt) begin
					nxt_state = CRPC_SLEEP;
				end
			end
			CRPC_RESET: begin
				if (!resetReq && !resetAct) begin
					nxt_state = CRPC_RUN;
				end
			end
			CRPC_SLEEP: begin
				if (resetReq || resetAct) begin
					nxt_state = CRPC_RESET;
				end else if (intEvt) begin
					nxt_state = CRPC_RUN;
				end
			end
			default: begin
				nxt_state = CRPC_RESET;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			state_ff <= CRPC_RESET;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign sleepOut       = state_ff == CRPC_SLEEP;
	assign coreClockEnOut = state_ff != CRPC_SLEEP;
	assign coreResetNOut  = coreResetN_ff;

	// =================================================================
	// Bus read channel
	wire [ADDR_W-3:0] rIdx = araddr[ADDR_W-1:2];
	wire hitRStatus = rIdx == STATUS_OFF[ADDR_W-1:2];
	wire hitRDebug  = rIdx == DEBUG_OFF[ADDR_W-1:2];
	wire hitRPower  = rIdx == POWER_OFF[ADDR_W-1:2];
	wire hitRCount  = rIdx == TCOUNT_OFF[ADDR_W-1:2];
	wire hitRCmp    = rIdx == TCMP_OFF[ADDR_W-1:2];
	wire hitRAny    = hitRStatus || hitRDebug || hitRPower ||
		hitRCount || hitRCmp;

	wire [DATA_W-1:0] statusWord = DATA_W'(
		(exceptionLevelBit_ff << EXL_BIT) |
		(errorLevelBit_ff << ERL_BIT) |
		(softResetFlag_ff << SOFT_BIT));
	wire [DATA_W-1:0] debugWord = DATA_W'(
		(debugModeBit_ff << DM_BIT) |
		(warmMaskReq_ff << WMASK_BIT));
	wire [DATA_W-1:0] powerWord = DATA_W'(
		(sleepOut << WAIT_BIT) |
		(resetAct << RSTACT_BIT) |
		(rstSync_ff[0] << WARMLVL_BIT) |
		(rstSync_ff[1] << COLDLVL_BIT) |
		(timerPend_ff << TPEND_BIT));

	wire [DATA_W-1:0] readMux =
		hitRStatus ? statusWord :
		hitRDebug  ? debugWord :
		hitRPower  ? powerWord :
		hitRCount  ? DATA_W'(timerCount_ff) :
		hitRCmp    ? DATA_W'(timerCmp_ff) : '0;

	assign arready = !rvalid_ff;

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			rvalid_ff <= 1'h0;
			rdata_ff  <= '0;
			rresp_ff  <= RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid_ff <= 1'h1;
			rdata_ff  <= readMux;
			rresp_ff  <= hitRAny ? RESP_OKAY : RESP_SLVERR;
		end else if (rready) begin
			rvalid_ff <= 1'h0;
		end
	end
	assign rvalid = rvalid_ff;
	assign rdata  = rdata_ff;
	assign rresp  = rresp_ff;

endmodule

/* File: inc/crpc_pkg.sv */
// =====================================================================
// Reset and power control constants
package crpc_pkg;

	// =================================================================
	// Bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int STRB_W = DATA_W / 8;

	// =================================================================
	// Register offsets (byte addresses)
	localparam logic [ADDR_W-1:0] STATUS_OFF = 8'h00;
	localparam logic [ADDR_W-1:0] DEBUG_OFF  = 8'h04;
	localparam logic [ADDR_W-1:0] POWER_OFF  = 8'h08;
	localparam logic [ADDR_W-1:0] TCOUNT_OFF = 8'h0c;
	localparam logic [ADDR_W-1:0] TCMP_OFF   = 8'h10;

	// =================================================================
	// Field positions
	localparam int EXL_BIT     = 1;
	localparam int ERL_BIT     = 2;
	localparam int SOFT_BIT    = 4;
	localparam int DM_BIT      = 30;
	localparam int WMASK_BIT   = 0;
	localparam int WAIT_BIT    = 0;
	localparam int RSTACT_BIT  = 1;
	localparam int WARMLVL_BIT = 2;
	localparam int COLDLVL_BIT = 3;
	localparam int TPEND_BIT   = 4;

	// =================================================================
	// Reset values and timing counts
	localparam logic        EXL_RST    = 1'h0;
	localparam logic        ERL_RST    = 1'h1;
	localparam logic [31:0] TCMP_RST   = 32'hffffffff;
	localparam logic [2:0]  RST_PULSE  = 3'h6;
	localparam logic [3:0]  TIMER_DIV  = 4'h2;

	// =================================================================
	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// =================================================================
	// Power states
	typedef enum logic [2:0] {
		CRPC_RUN   = 3'h1,
		CRPC_RESET = 3'h2,
		CRPC_SLEEP = 3'h4
	} crpc_state_e;

endpackage

/* File: testbench/crpc_core_reset_power_monitor.sv */
`timescale 1ns/1ps
module crpc_core_reset_power_monitor #(
	parameter int INT_W = 8
) (
	// Clock and reset
	input wire logic             mclk,
	input wire logic             nrst,
	// Pins
	input wire logic             coldResetNIn,
	input wire logic             warmResetNIn,
	input wire logic [INT_W-1:0] intIn,
	input wire logic             nmiIn,
	input wire logic             errorLevelOut,
	input wire logic             debugModeOut,
	input wire logic             sleepOut,
	input wire logic             coreClockEnOut,
	input wire logic             coreResetNOut,
	// Bus answers
	input wire logic             rvalid,
	input wire logic             rready,
	input wire logic [31:0]      rdata,
	input wire logic             bvalid,
	input wire logic             bready,
	input wire logic [1:0]       bresp
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	// ================================================================
	// Reset pulse
	rst_pulse_a: assert property (
		$rose(coreResetNOut) |-> !$past(coreResetNOut) &&
		!$past(coreResetNOut, 6)) else $error("reset pulse short");
	cold_rst_a: assert property (
		!coldResetNIn |-> ##[1:4] !coreResetNOut)
		else $error("cold reset missed");
	warm_rst_a: assert property (
		!warmResetNIn && !debugModeOut |-> ##[1:4] !coreResetNOut)
		else $error("warm reset missed");
	dbg_cold_a: assert property (
		$fell(coldResetNIn) |-> ##[1:4] !debugModeOut)
		else $error("debug mode kept");
	err_lvl_a: assert property (
		!coreResetNOut |-> ##[0:1] errorLevelOut)
		else $error("error level low in reset");

	// ================================================================
	// Sleep
	clk_en_a: assert property (
		coreClockEnOut != sleepOut) else $error("clock enable wrong");
	wake_int_a: assert property (
		sleepOut && (|intIn || nmiIn) |=> !sleepOut)
		else $error("no wake on interrupt");
	wake_rst_a: assert property (
		sleepOut && !coldResetNIn |-> ##[1:4] !sleepOut)
		else $error("no wake on reset");

	// ================================================================
	// Bus answers
	rd_hold_a: assert property (
		rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped");
	wr_hold_a: assert property (
		bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write answer dropped");
endmodule

bind crpc_core_reset_power crpc_core_reset_power_monitor #(.INT_W(INT_W))
	u_mon (.*);

/* File: testbench/crpc_core_reset_power_tb.sv */
`timescale 1ns/1ps
module crpc_core_reset_power_tb;
	import crpc_pkg::*;
	logic        mclk = 0;
	logic        nrst = 0;
	logic        warmResetNIn, coldResetNIn, nmiIn;
	logic [7:0]  intIn;
	logic        exceptionLevelOut, errorLevelOut, debugModeOut;
	logic        sleepOut, coreClockEnOut, coreResetNOut;
	logic        awvalid = 0, wvalid = 0, bready = 0;
	logic        arvalid = 0, rready = 0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [7:0]  awaddr = 0, araddr = 0;
	logic [2:0]  awprot = 0, arprot = 0;
	logic [31:0] wdata = 0, rdata, v;
	logic [3:0]  wstrb = 0;
	logic [1:0]  bresp, rresp;
	int          bad_count = 0, n_checks = 0, cyc = 0;

	always #25 mclk = ~mclk;
	crpc_core_reset_power u_dut (.*);
	crpc_sys_agent u_sys (.mclk, .warmResetNIn, .coldResetNIn, .intIn,
		.nmiIn);

	// ================================================================
	// Reporting
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			final_report();
		end
	end
	task automatic chk(input string n, input logic [31:0] e, g);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask

	// ================================================================
	// Bus tasks
	task automatic step;
		@(posedge mclk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		@(posedge mclk);
		awvalid <= 1;
		wvalid <= 1;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		do begin
			@(posedge mclk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
			if (bvalid) bready <= 1;
		end while (!(bvalid && bready));
		bready <= 0;
		chk("bresp", er, bresp);
	endtask
	task automatic rd(input logic [7:0] a, input logic [1:0] er);
		@(posedge mclk);
		arvalid <= 1;
		araddr <= a;
		do begin
			@(posedge mclk);
			if (arready) arvalid <= 0;
			if (rvalid) rready <= 1;
		end while (!(rvalid && rready));
		rready <= 0;
		v = rdata;
		chk("rresp", er, rresp);
	endtask
	task automatic pulse(input logic w, c, input logic [31:0] e);
		logic [31:0] n;
		n = 0;
		u_sys.pins(w, c, 1);
		repeat (12) begin
			step();
			n += !coreResetNOut;
		end
		chk("pulse", e, n);
	endtask

	// ================================================================
	// Tests
	initial begin
		repeat (16) @(posedge mclk);
		nrst <= 1;
		while (coreResetNOut !== 1) step();
		rd(STATUS_OFF, RESP_OKAY);
		chk("erl", 1, v[ERL_BIT]);
		chk("soft", 0, v[SOFT_BIT]);
		$display("reset test done");
		wr(STATUS_OFF, 32'h00000002, RESP_OKAY);
		step();
		chk("exlOut", 1, exceptionLevelOut);
		chk("erlOut", 0, errorLevelOut);
		wr(STATUS_OFF, 32'h00000004, RESP_OKAY);
		step();
		chk("exlOut", 0, exceptionLevelOut);
		chk("erlOut", 1, errorLevelOut);
		wr(DEBUG_OFF, 32'h40000001, RESP_OKAY);
		step();
		chk("dbgOut", 1, debugModeOut);
		pulse(0, 1, 0);
		wr(DEBUG_OFF, 32'h40000000, RESP_OKAY);
		pulse(0, 1, 6);
		rd(STATUS_OFF, RESP_OKAY);
		chk("soft", 1, v[SOFT_BIT]);
		wr(DEBUG_OFF, 32'h40000001, RESP_OKAY);
		pulse(1, 0, 6);
		chk("dbgOut", 0, debugModeOut);
		rd(STATUS_OFF, RESP_OKAY);
		chk("soft", 0, v[SOFT_BIT]);
		wr(STATUS_OFF, 32'h00000000, RESP_OKAY);
		step();
		chk("erlOut", 0, errorLevelOut);
		pulse(0, 0, 6);
		chk("erlOut", 1, errorLevelOut);
		rd(STATUS_OFF, RESP_OKAY);
		chk("soft", 0, v[SOFT_BIT]);
		$display("reset pin test done");
		for (int i = 0; i < 9; i++) begin
			wr(POWER_OFF, 32'h00000001, RESP_OKAY);
			step();
			chk("sleep", 1, sleepOut);
			chk("clkEn", 0, coreClockEnOut);
			rd(POWER_OFF, RESP_OKAY);
			chk("waitBit", 1, v[WAIT_BIT]);
			u_sys.set_src(i, 1);
			step();
			chk("sleep", 0, sleepOut);
			chk("clkEn", 1, coreClockEnOut);
			u_sys.set_src(i, 0);
		end
		u_sys.set_src(8, 1);
		wr(POWER_OFF, 32'h00000001, RESP_OKAY);
		step();
		chk("sleep", 0, sleepOut);
		u_sys.set_src(8, 0);
		wr(POWER_OFF, 32'h00000001, RESP_OKAY);
		pulse(1, 0, 6);
		chk("sleep", 0, sleepOut);
		wr(TCMP_OFF, 32'h00000040, RESP_OKAY);
		wr(TCOUNT_OFF, 32'h00000000, RESP_OKAY);
		wr(POWER_OFF, 32'h00000001, RESP_OKAY);
		step();
		chk("sleep", 1, sleepOut);
		repeat (160) step();
		chk("sleep", 0, sleepOut);
		rd(POWER_OFF, RESP_OKAY);
		chk("tPend", 1, v[TPEND_BIT]);
		wr(POWER_OFF, 32'h00000010, RESP_OKAY);
		rd(POWER_OFF, RESP_OKAY);
		chk("tPend", 0, v[TPEND_BIT]);
		$display("sleep test done");
		wr(8'h20, 32'h00000005, RESP_SLVERR);
		rd(8'h20, RESP_SLVERR);
		chk("rdata", 0, v);
		$display("bus test done");
		final_report();
	end
endmodule

/* File: testbench/crpc_sys_agent.sv */
`timescale 1ns/1ps
module crpc_sys_agent (
	// Clock
	input wire logic  mclk,
	// Reset and wake lines
	output logic       warmResetNIn,
	output logic       coldResetNIn,
	output logic [7:0] intIn,
	output logic       nmiIn
);
	initial begin
		warmResetNIn = 1'h1;
		coldResetNIn = 1'h0;
		intIn = 8'h00;
		nmiIn = 1'h0;
		repeat (20) @(posedge mclk);
		coldResetNIn <= 1'h1;
	end

	task automatic pins(input logic w, c, input int n);
		@(posedge mclk);
		warmResetNIn <= w;
		coldResetNIn <= c;
		repeat (n) @(posedge mclk);
		warmResetNIn <= 1'h1;
		coldResetNIn <= 1'h1;
	endtask

	task automatic set_src(input int i, input logic v);
		@(posedge mclk);
		if (i == 8) nmiIn <= v;
		else intIn[i] <= v;
	endtask
endmodule
